//--- rtl/drt_pkg.sv
// Operation
// - Answer addresses 7Ah write, 7Bh read, and 19h read only while an alert is pending
// - Support Write/Read/Send/Receive Byte transfers
// - Results are 8-bit two's complement, 1 C/LSB
// - Free-running conversions or single-shot on request
// - Rate byte 04h gives one conversion per second
// - Conversion done 125 ms after triggering stop
// - Channel one critical faults count toward shutdown
// - Channel two has its own identical fault counter
// - Shutdown output is push-pull, high when active
// - Reset output low, then 140 ms after recovery
// - Open-drain alert plus alert response transaction
// - Serial port static, DC up to 100 kHz
// - Undervoltage lockout inhibits all conversions
// - Hold delay after clock fall covers 300 ns
// - Busy reads return previous complete results
// - Compare each result with high and low limits
package drt_pkg;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int         CLK_MHZ        = 200;
   localparam int         HOLD_NS        = 300;
   localparam logic [6:0] HOLD_CYC       = 7'((HOLD_NS * CLK_MHZ + 999) / 1000);
   localparam int         MS_CYC         = CLK_MHZ * 1000;
   localparam int         CONV_MS        = 125;
   localparam int         RST_MS         = 140;
   localparam int         PERIOD_BASE_MS = 16000;
   localparam logic [7:0] RATE_MAX       = 8'h07;

   // ----------------------------------------
   // Bus addresses and command codes
   // ----------------------------------------
   localparam logic [7:0] ADDR_WR     = 8'h7a;
   localparam logic [7:0] ADDR_RD     = 8'h7b;
   localparam logic [7:0] ARA_RD      = 8'h19;
   localparam logic [7:0] CMD_T1      = 8'h00;
   localparam logic [7:0] CMD_T2      = 8'h01;
   localparam logic [7:0] CMD_STAT    = 8'h02;
   localparam logic [7:0] CMD_CFG     = 8'h03;
   localparam logic [7:0] CMD_RATE    = 8'h04;
   localparam logic [7:0] CMD_HI1     = 8'h05;
   localparam logic [7:0] CMD_LO1     = 8'h06;
   localparam logic [7:0] CMD_HI2     = 8'h07;
   localparam logic [7:0] CMD_LO2     = 8'h08;
   localparam logic [7:0] CMD_ONESHOT = 8'h0f;
   localparam logic [7:0] CMD_CRIT1   = 8'h35;
   localparam logic [7:0] CMD_CRIT2   = 8'h36;
   localparam logic [7:0] CMD_FAULTS  = 8'h37;

   // ----------------------------------------
   // Reset values and fields
   // ----------------------------------------
   localparam logic [7:0] CFG_RST    = 8'h00;
   localparam logic [7:0] RATE_RST   = 8'h04;
   localparam logic [7:0] HI_RST     = 8'h7f;
   localparam logic [7:0] LO_RST     = 8'hc9;
   localparam logic [7:0] CRIT_RST   = 8'h64;
   localparam logic [7:0] FAULTS_RST = 8'h01;
   localparam int         CFG_SINGLE = 0;
   localparam int         STAT_BUSY  = 7;

   typedef enum logic [2:0] {
      SB_IDLE, SB_ADDR, SB_CMD, SB_WDATA, SB_READ, SB_ARA
   } drt_smb_st_t;

endpackage

//--- rtl/drt_link_shift.sv
`timescale 1ns/1ps
module drt_link_shift (
   // Link side
   input  wire logic       smb_clk_i,
   input  wire logic       resetn_i,
   input  wire logic       smb_data_i,
   // Captured byte
   output logic [7:0]      byte_o
);

   // Bits enter on the serial clock's own rising edge; the byte is read
   // by the system side only while the serial clock is low and steady.
   always_ff @(posedge smb_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         byte_o <= 8'h00;
      end else begin
         byte_o <= {byte_o[6:0], smb_data_i};
      end
   end

endmodule // drt_link_shift

//--- rtl/drt_monitor.sv
`timescale 1ns/1ps
module drt_monitor #(
   parameter int MS_CYCLES = drt_pkg::MS_CYC,
   parameter int RESET_MS  = drt_pkg::RST_MS
) (
   // System
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   // Serial bus
   input  wire logic       smb_clk_i,
   input  wire logic       smb_data_i,
   output logic            smb_data_o,
   output logic            smb_data_oe_o,
   output logic            alert_o,
   output logic            alert_oe_o,
   // Converter front end
   input  wire logic [7:0] remote_channel_one_i,
   input  wire logic [7:0] remote_channel_two_i,
   output logic            adc_run_o,
   // Supply monitors
   input  wire logic       uvlo_ok_i,
   input  wire logic       supply_ok_i,
   // System outputs
   output logic            overheat_shutdown_out_o,
   output logic            sys_reset_n_o
);
   import drt_pkg::*;

   localparam logic [31:0] MS_LIM   = 32'(MS_CYCLES - 1);
   localparam logic [31:0] CONV_LIM = 32'(CONV_MS * MS_CYCLES - 1);
   localparam logic [31:0] RST_LIM  = 32'(RESET_MS * MS_CYCLES);

   // ----------------------------------------
   // Synchronisers and serial edges
   // ----------------------------------------
   logic [1:0] scl_sy, sda_sy, uv_sy, sup_sy;
   logic       scl_q, sda_q;
   logic [6:0] hold_cnt;
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         scl_sy <= 2'h3;
         sda_sy <= 2'h3;
         uv_sy  <= 2'h0;
         sup_sy <= 2'h0;
         scl_q  <= 1'b1;
         sda_q  <= 1'b1;
      end else begin
         scl_sy <= {scl_sy[0], smb_clk_i};
         sda_sy <= {sda_sy[0], smb_data_i};
         uv_sy  <= {uv_sy[0], uvlo_ok_i};
         sup_sy <= {sup_sy[0], supply_ok_i};
         scl_q  <= scl_sy[1];
         sda_q  <= sda_sy[1];
      end
   end
   wire scl_s    = scl_sy[1];
   wire sda_s    = sda_sy[1];
   wire uv_ok    = uv_sy[1];
   wire sup_ok   = sup_sy[1];
   wire start    = scl_s & scl_q & sda_q & ~sda_s;
   wire stop     = scl_s & scl_q & ~sda_q & sda_s;
   wire scl_rise = scl_s & ~scl_q;
   wire scl_fall = ~scl_s & scl_q;
   wire fall_d   = (hold_cnt == 7'h01);

   // Data output only moves once the falling clock edge has fully settled
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         hold_cnt <= 7'h00;
      end else if (scl_fall) begin
         hold_cnt <= HOLD_CYC;
      end else if (hold_cnt != 7'h00) begin
         hold_cnt <= hold_cnt - 7'h01;
      end
   end

   // ----------------------------------------
   // Serial slave engine
   // ----------------------------------------
   drt_smb_st_t st;
   logic [3:0]  bit_cnt;
   logic [7:0]  ptr, tx, wdat, rd_data;
   logic        sda_oe, mack, wr_en, stat_rd, ara_win, oneshot, oneshot_pend;
   logic        alert_q;
   logic [7:0]  rx;

   drt_link_shift u_shift (
      .smb_clk_i  (smb_clk_i),
      .resetn_i   (resetn_i),
      .smb_data_i (smb_data_i),
      .byte_o     (rx)
   );

   wire       ack_ph   = fall_d && (bit_cnt == 4'h8);
   wire       rd_st    = (st == SB_READ) || (st == SB_ARA);
   wire       ara_hit  = (rx == ARA_RD) && alert_q;
   wire       addr_hit = (rx == ADDR_WR) || (rx == ADDR_RD) || ara_hit;
   wire [2:0] tx_idx   = 3'h7 - bit_cnt[2:0];

   // The received byte is stable from the eighth rising edge to the ninth,
   // which the settled falling edge always lies between.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st <= SB_IDLE;
         bit_cnt <= 4'h0;
         {ptr, tx, wdat} <= {3{8'h00}};
         {sda_oe, mack, wr_en, stat_rd, ara_win, oneshot, oneshot_pend} <= 7'h00;
      end else begin
         wr_en   <= 1'b0;
         stat_rd <= 1'b0;
         ara_win <= 1'b0;
         oneshot <= 1'b0;
         if (start) begin
            st      <= SB_ADDR;
            bit_cnt <= 4'h0;
            sda_oe  <= 1'b0;
         end else if (stop) begin
            st           <= SB_IDLE;
            bit_cnt      <= 4'h0;
            sda_oe       <= 1'b0;
            oneshot      <= oneshot_pend;
            oneshot_pend <= 1'b0;
         end else begin
            if (scl_rise && st != SB_IDLE) begin
               bit_cnt <= (bit_cnt == 4'h9) ? 4'h1 : bit_cnt + 4'h1;
               if (bit_cnt == 4'h8) begin
                  mack <= ~sda_s;
               end
            end
            if (ack_ph) begin
               case (st)
                  SB_ADDR: begin
                     sda_oe  <= addr_hit;
                     st      <= (rx == ADDR_WR) ? SB_CMD : (rx == ADDR_RD) ? SB_READ :
                                ara_hit ? SB_ARA : SB_IDLE;
                     tx      <= (rx == ADDR_RD) ? rd_data : ADDR_WR;
                     stat_rd <= (rx == ADDR_RD) && (ptr == CMD_STAT);
                     ara_win <= ara_hit;
                  end
                  SB_CMD: begin
                     sda_oe       <= 1'b1;
                     ptr          <= rx;
                     oneshot_pend <= (rx == CMD_ONESHOT);
                     st           <= SB_WDATA;
                  end
                  SB_WDATA: begin
                     sda_oe <= 1'b1;
                     wr_en  <= 1'b1;
                     wdat   <= rx;
                  end
                  default: sda_oe <= 1'b0;
               endcase
            end else if (fall_d && bit_cnt == 4'h9) begin
               // A master that does not acknowledge must be free to stop
               sda_oe <= rd_st && mack && !tx[7];
               if (rd_st && !mack) begin
                  st <= SB_IDLE;
               end
            end else if (fall_d && rd_st && bit_cnt != 4'h0) begin
               sda_oe <= !tx[tx_idx];
            end
         end
      end
   end

   // ----------------------------------------
   // Register file
   // ----------------------------------------
   logic [7:0] cfg, rate, hi1, lo1, hi2, lo2, crit1, crit2, faults;
   logic [7:0] t1, t2;
   logic [3:0] flags;
   logic       busy;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         {cfg, rate, faults} <= {CFG_RST, RATE_RST, FAULTS_RST};
         {hi1, lo1, hi2, lo2} <= {HI_RST, LO_RST, HI_RST, LO_RST};
         {crit1, crit2} <= {CRIT_RST, CRIT_RST};
      end else if (wr_en) begin
         case (ptr)
            CMD_CFG:    cfg    <= wdat;
            CMD_RATE:   rate   <= wdat;
            CMD_HI1:    hi1    <= wdat;
            CMD_LO1:    lo1    <= wdat;
            CMD_HI2:    hi2    <= wdat;
            CMD_LO2:    lo2    <= wdat;
            CMD_CRIT1:  crit1  <= wdat;
            CMD_CRIT2:  crit2  <= wdat;
            CMD_FAULTS: faults <= wdat;
            default:    ;
         endcase
      end
   end

   always_comb begin
      case (ptr)
         CMD_T1:     rd_data = t1;
         CMD_T2:     rd_data = t2;
         CMD_STAT:   rd_data = {busy, flags, 3'h0};
         CMD_CFG:    rd_data = cfg;
         CMD_RATE:   rd_data = rate;
         CMD_HI1:    rd_data = hi1;
         CMD_LO1:    rd_data = lo1;
         CMD_HI2:    rd_data = hi2;
         CMD_LO2:    rd_data = lo2;
         CMD_CRIT1:  rd_data = crit1;
         CMD_CRIT2:  rd_data = crit2;
         CMD_FAULTS: rd_data = faults;
         default:    rd_data = 8'h00;
      endcase
   end

   // ----------------------------------------
   // Conversion timing
   // ----------------------------------------
   logic [31:0] ms_cnt, cv_cyc;
   logic [13:0] per_ms;
   wire  [7:0]  rate_eff = (rate > RATE_MAX) ? RATE_MAX : rate;
   wire  [13:0] per_lim  = 14'(PERIOD_BASE_MS) >> rate_eff[2:0];
   wire         ms_tick  = (ms_cnt == MS_LIM);
   wire         per_end  = ms_tick && (per_ms >= per_lim - 14'h1);
   wire         free_run = !cfg[CFG_SINGLE];
   wire         start_cv = uv_ok && !busy && (oneshot || (free_run && per_end));
   wire         cv_done  = busy && (cv_cyc == CONV_LIM);

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ms_cnt <= 32'h0;
         per_ms <= 14'h0;
      end else begin
         ms_cnt <= ms_tick ? 32'h0 : ms_cnt + 32'h1;
         if (ms_tick) begin
            per_ms <= per_end ? 14'h0 : per_ms + 14'h1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         busy   <= 1'b0;
         cv_cyc <= 32'h0;
      end else if (!uv_ok || cv_done) begin
         busy   <= 1'b0;
         cv_cyc <= 32'h0;
      end else if (start_cv) begin
         busy   <= 1'b1;
         cv_cyc <= 32'h0;
      end else if (busy) begin
         cv_cyc <= cv_cyc + 32'h1;
      end
   end

   // ----------------------------------------
   // Results, limits and faults
   // ----------------------------------------
   logic [3:0] f1, f2;
   wire  [7:0] a1 = remote_channel_one_i;
   wire  [7:0] a2 = remote_channel_two_i;
   wire  [3:0] oor = {$signed(a1) > $signed(hi1), $signed(a1) < $signed(lo1),
                      $signed(a2) > $signed(hi2), $signed(a2) < $signed(lo2)};
   wire  [3:0] new_f = cv_done ? oor : 4'h0;
   wire  [3:0] fc    = (faults[3:0] == 4'h0) ? 4'h1 : faults[3:0];
   wire        hot1  = $signed(a1) >= $signed(crit1);
   wire        hot2  = $signed(a2) >= $signed(crit2);

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         {t1, t2} <= 16'h0000;
         flags    <= 4'h0;
         alert_q  <= 1'b0;
      end else begin
         if (cv_done) begin
            t1 <= a1;
            t2 <= a2;
         end
         // A new event beats a clear in the same cycle
         flags   <= (flags & ~{4{stat_rd}}) | new_f;
         alert_q <= (alert_q & ~stat_rd & ~ara_win) | (|new_f);
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         f1 <= 4'h0;
         f2 <= 4'h0;
      end else if (cv_done) begin
         f1 <= hot1 ? ((f1 < fc) ? f1 + 4'h1 : f1) : 4'h0;
         f2 <= hot2 ? ((f2 < fc) ? f2 + 4'h1 : f2) : 4'h0;
      end
   end

   // ----------------------------------------
   // Supply reset timer and outputs
   // ----------------------------------------
   logic [31:0] rst_cyc;
   logic        rst_n, shut;
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_cyc <= 32'h0;
         rst_n   <= 1'b0;
         shut    <= 1'b0;
      end else begin
         shut <= (f1 >= fc) || (f2 >= fc);
         if (!sup_ok) begin
            rst_cyc <= 32'h0;
            rst_n   <= 1'b0;
         end else if (rst_cyc == RST_LIM) begin
            rst_n <= 1'b1;
         end else begin
            rst_cyc <= rst_cyc + 32'h1;
         end
      end
   end

   assign smb_data_o              = 1'b0;
   assign smb_data_oe_o           = sda_oe;
   assign alert_o                 = 1'b0;
   assign alert_oe_o              = alert_q;
   assign adc_run_o               = busy;
   assign overheat_shutdown_out_o = shut;
   assign sys_reset_n_o           = rst_n;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   sequence s_done_oor;
      cv_done && (|oor);
   endsequence
   sequence s_alert_up;
      alert_oe_o ##1 alert_oe_o;
   endsequence

   property p_addr;
      (ack_ph && st == SB_ADDR && !addr_hit) |=> !smb_data_oe_o && st == SB_IDLE;
   endproperty
   a_addr: assert property (p_addr) else $error("Foreign address acknowledged");

   property p_rate;
      (rate == 8'h04) |-> (per_lim == 14'd1000);
   endproperty
   a_rate: assert property (p_rate) else $error("Rate 04h not one second");

   property p_conv_end;
      (busy && uv_ok && cv_cyc == CONV_LIM) |=> !busy && (t1 == $past(a1)) && (t2 == $past(a2));
   endproperty
   a_conv_end: assert property (p_conv_end) else $error("Conversion end wrong");

   property p_shut;
      (cv_done && hot1 && f1 == fc - 4'h1) |=> ##1 overheat_shutdown_out_o;
   endproperty
   a_shut: assert property (p_shut) else $error("Shutdown missed");

   property p_restart;
      (cv_done && !hot2) |=> (f2 == 4'h0);
   endproperty
   a_restart: assert property (p_restart) else $error("Fault count not cleared");

   property p_rst_low;
      !sup_ok |=> !sys_reset_n_o [*2];
   endproperty
   a_rst_low: assert property (p_rst_low) else $error("Reset released early");

   property p_uvlo;
      !uv_ok |=> !adc_run_o;
   endproperty
   a_uvlo: assert property (p_uvlo) else $error("Conversion under lockout");

   property p_hold;
      scl_fall |=> $stable(smb_data_oe_o) [*8] ##52 $stable(smb_data_oe_o);
   endproperty
   a_hold: assert property (p_hold) else $error("Data changed inside hold");

   property p_keep;
      !cv_done |=> $stable(t1) && $stable(t2);
   endproperty
   a_keep: assert property (p_keep) else $error("Result changed while busy");

   property p_alert;
      s_done_oor |=> s_alert_up;
   endproperty
   a_alert: assert property (p_alert) else $error("Alert not raised");

endmodule // drt_monitor

//--- dv/drt_host_model.sv
`timescale 1ns/1ps
module drt_host_model #(
   parameter int HALF_NS = 352
) (
   // Bus lines
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_oe_o
);
   import drt_pkg::*;

   // Clock idles high between frames and data idles released
   initial begin
      scl_o    = 1'b1;
      sda_oe_o = 1'b0;
   end

   // ----------------------------------------
   // Bit level
   // ----------------------------------------
   // Half period scaled just past the device hold delay; the port is static
   task automatic bit_out(input logic b);
      sda_oe_o = !b;
      #HALF_NS scl_o = 1'b1;
      #HALF_NS scl_o = 1'b0;
   endtask

   task automatic bit_in(output logic b);
      sda_oe_o = 1'b0;
      #HALF_NS scl_o = 1'b1;
      b = sda_i;
      #HALF_NS scl_o = 1'b0;
   endtask

   // Release before raising the clock, so a late slave ack cannot look like a stop
   task automatic start();
      sda_oe_o = 1'b0;
      #HALF_NS scl_o = 1'b1;
      #HALF_NS sda_oe_o = 1'b1;
      #HALF_NS scl_o = 1'b0;
   endtask

   task automatic stop();
      sda_oe_o = 1'b1;
      #HALF_NS scl_o = 1'b1;
      #HALF_NS sda_oe_o = 1'b0;
      #HALF_NS;
   endtask

   task automatic put(input logic [7:0] v, inout logic ok);
      logic a;
      for (int i = 7; i >= 0; i--) begin
         bit_out(v[i]);
      end
      bit_in(a);
      ok = ok && !a;
   endtask

   // Nack after the byte ends the read
   task automatic get(output logic [7:0] v);
      for (int i = 7; i >= 0; i--) begin
         bit_in(v[i]);
      end
      bit_out(1'b1);
   endtask

   // ----------------------------------------
   // Transfers: 0 write, 1 send, 2 read, 3 receive, 4 address only
   // ----------------------------------------
   task automatic xfer(input int kind, input logic [7:0] adr, cmd, wd,
                       output logic [7:0] rd, output logic ok);
      ok = 1'b1;
      rd = 8'h00;
      start();
      put(adr, ok);
      if (kind < 3) begin
         put(cmd, ok);
      end
      if (kind == 0) begin
         put(wd, ok);
      end
      if (kind == 2) begin
         start();
         put(ADDR_RD, ok);
      end
      if (kind == 2 || kind == 3) begin
         get(rd);
      end
      stop();
   endtask
endmodule // drt_host_model

//--- dv/testbench.sv
`timescale 1ns/1ps
module testbench;
   import drt_pkg::*;
   localparam int MS   = 20;
   localparam int RMS  = 3;
   localparam int CONV = CONV_MS * MS;

   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic       clk_i;
   logic       resetn_i;
   logic       scl;
   logic       host_oe;
   logic       dut_oe;
   logic       alert_oe;
   logic       run;
   logic       run_q;
   logic       shut;
   logic       rst_n;
   logic [7:0] ch1;
   logic [7:0] ch2;
   logic       uvlo_ok;
   logic       supply_ok;
   int         fails;
   int         check_count;
   int         starts;
   longint     cyc;
   // Open-drain data line with pull-up
   wire        sda = !(host_oe || dut_oe);

   drt_monitor #(.MS_CYCLES(MS), .RESET_MS(RMS)) i_dut (
      .clk_i(clk_i), .resetn_i(resetn_i), .smb_clk_i(scl), .smb_data_i(sda),
      .smb_data_o(), .smb_data_oe_o(dut_oe), .alert_o(), .alert_oe_o(alert_oe),
      .remote_channel_one_i(ch1), .remote_channel_two_i(ch2), .adc_run_o(run),
      .uvlo_ok_i(uvlo_ok), .supply_ok_i(supply_ok),
      .overheat_shutdown_out_o(shut), .sys_reset_n_o(rst_n));

   drt_host_model #(.HALF_NS(352)) i_host (.sda_i(sda), .scl_o(scl), .sda_oe_o(host_oe));

   always #2.5 clk_i = !clk_i;

   always @(posedge clk_i) begin
      cyc   <= cyc + 1;
      run_q <= run;
      if (run && !run_q) begin
         starts <= starts + 1;
      end
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic check(input string name, input logic [15:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic set_in(input logic [7:0] a, b);
      step(1);
      ch1 = a;
      ch2 = b;
   endtask

   task automatic bus(input int kind, input logic [7:0] adr, cmd, wd, output logic [7:0] rd);
      logic ok;
      i_host.xfer(kind, adr, cmd, wd, rd, ok);
      check("ack", ok, kind != 4);
   endtask

   task automatic wait_run(input logic lvl, input int lim, output int n);
      n = 0;
      while (run !== lvl && n < lim) begin
         step(1);
         n++;
      end
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      int n;
      for (int k = 0; k < 2; k++) begin
         check("reset_low", rst_n, 1'b0);
         supply_ok = 1'b1;
         n = 0;
         while (rst_n !== 1'b1 && n < 200) begin
            step(1);
            n++;
         end
         check("reset_hold", n >= RMS * MS && n <= RMS * MS + 8, 1'b1);
         supply_ok = k[0];
         step(6);
      end
   endtask

   task automatic t_regs();
      logic [7:0] rd;
      bus(4, 8'h7c, 8'h00, 8'h00, rd);
      bus(2, ADDR_WR, CMD_CRIT1, 8'h00, rd);
      check("crit_rst", rd, CRIT_RST);
      bus(0, ADDR_WR, CMD_CRIT1, 8'h1e, rd);
      bus(2, ADDR_WR, CMD_CRIT1, 8'h00, rd);
      check("crit_wr", rd, 8'h1e);
   endtask

   // Channel one exactly at its limit, channel two one below its low limit
   task automatic t_conv();
      logic [7:0] rd;
      int n;
      bus(0, ADDR_WR, CMD_CFG, 8'h01, rd);
      set_in(8'h1e, 8'hc8);
      bus(1, ADDR_WR, CMD_ONESHOT, 8'h00, rd);
      check("busy", run, 1'b1);
      wait_run(1'b0, CONV + 10, n);
      check("conv_time", n > CONV - 100 && n <= CONV, 1'b1);
      step(3);
      check("shutdown", shut, 1'b1);
      check("alert", alert_oe, 1'b1);
      bus(3, ARA_RD, 8'h00, 8'h00, rd);
      check("ara", rd, ADDR_WR);
      check("alert_clr", alert_oe, 1'b0);
      bus(2, ADDR_WR, CMD_STAT, 8'h00, rd);
      check("status", rd, 8'h08);
      bus(2, ADDR_WR, CMD_T2, 8'h00, rd);
      check("ch2", rd, 8'hc8);
   endtask

   // Fault count of two: one hot conversion must not trip, the second must
   task automatic t_faults();
      logic [7:0] rd;
      int n;
      int s0;
      s0 = starts;
      bus(0, ADDR_WR, CMD_FAULTS, 8'h02, rd);
      for (int k = 0; k < 2; k++) begin
         set_in(8'h1d, 8'h64);
         bus(1, ADDR_WR, CMD_ONESHOT, 8'h00, rd);
         wait_run(1'b0, CONV, n);
         step(3);
         check("shut_ch2", shut, k[0]);
      end
      set_in(8'h1d, 8'h10);
      bus(1, ADDR_WR, CMD_ONESHOT, 8'h00, rd);
      wait_run(1'b0, CONV, n);
      step(3);
      check("shut_cool", shut, 1'b0);
      uvlo_ok = 1'b0;
      bus(1, ADDR_WR, CMD_ONESHOT, 8'h00, rd);
      wait_run(1'b1, 100, n);
      uvlo_ok = 1'b1;
      check("starts", 16'(starts - s0), 16'h0003);
   endtask

   task automatic t_free();
      logic [7:0] rd;
      int n;
      longint t0;
      bus(0, ADDR_WR, CMD_CFG, 8'h00, rd);
      bus(2, ADDR_WR, CMD_T1, 8'h00, rd);
      check("t1", rd, 8'h1d);
      wait_run(1'b0, CONV, n);
      wait_run(1'b1, 21000, n);
      t0 = cyc;
      set_in(8'h2a, 8'h10);
      bus(3, ADDR_RD, 8'h00, 8'h00, rd);
      check("t1_busy", rd, 8'h1d);
      wait_run(1'b0, CONV, n);
      bus(3, ADDR_RD, 8'h00, 8'h00, rd);
      check("t1_new", rd, 8'h2a);
      wait_run(1'b1, 21000, n);
      check("period", 16'(cyc - t0), 16'(1000 * MS));
   endtask

   // ----------------------------------------
   // Sequence and verdict
   // ----------------------------------------
   task automatic end_sim();
      $display("checks %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      clk_i       = 1'b0;
      resetn_i    = 1'b0;
      ch1         = 8'h00;
      ch2         = 8'h00;
      uvlo_ok     = 1'b1;
      supply_ok   = 1'b1;
      fails       = 0;
      check_count = 0;
      starts      = 0;
      cyc         = 0;
      run_q       = 1'b0;
      step(3);
      resetn_i = 1'b1;
      t_reset();
      t_regs();
      t_conv();
      t_faults();
      t_free();
      end_sim();
   end

   // Whole sequence needs about 100k cycles
   initial begin
      #(200000 * 5);
      fails++;
      end_sim();
   end
endmodule // testbench
